//--- include/pflb_pkg.sv
package pflb_pkg;
    // ==========================================
    // register map (word index = byte address here)
    localparam logic [3:0]  ADDR_BLANK_CTRL  = 4'h0;
    localparam logic [3:0]  ADDR_FAULT_CTRL  = 4'h1;
    localparam logic [3:0]  ADDR_BLANK_TIME  = 4'h2;
    localparam logic [3:0]  ADDR_AUX_CTRL    = 4'h3;
    localparam logic [3:0]  ADDR_STATUS      = 4'h4;
    localparam logic [3:0]  ADDR_FAULT_CLEAR = 4'h5;
    // ==========================================
    // blanking control fields
    localparam int BIT_HI_RISE   = 15;
    localparam int BIT_HI_FALL   = 14;
    localparam int BIT_LO_RISE   = 13;
    localparam int BIT_LO_FALL   = 12;
    localparam int BIT_FLT_BLANK = 11;
    localparam int BIT_LIM_BLANK = 10;
    localparam int BIT_SEL_HIGH  = 5;
    localparam int BIT_SEL_LOW   = 4;
    localparam int BIT_HI_HIGH   = 3;
    localparam int BIT_HI_LOW    = 2;
    localparam int BIT_LO_HIGH   = 1;
    localparam int BIT_LO_LOW    = 0;
    localparam logic [15:0] BLANK_CTRL_MASK  = 16'hfc3f;
    localparam logic [15:0] BLANK_CTRL_RESET = 16'h0000;
    // ==========================================
    // fault control fields: mode in [1:0], source enables in [6:2]
    localparam int FAULT_MODE_LSB  = 0;
    localparam int FAULT_EN_LSB    = 2;
    localparam int N_FAULTS        = 5;
    localparam int SAFETY_IDX      = 4;
    localparam logic [1:0] MODE_LATCHED = 2'h0;
    localparam logic [1:0] MODE_CYCLE   = 2'h1;
    localparam logic [1:0] MODE_OFF     = 2'h3;
    localparam logic [6:0] FAULT_CTRL_RESET = 7'h40;
    localparam logic [15:0] BLANK_TIME_RESET = 16'h0000;
    localparam int AUX_SEL_W = 4;
    // ==========================================
    typedef enum logic [1:0] {
        PFLB_IDLE  = 2'b01,
        PFLB_BLANK = 2'b10
    } pflb_blank_state_t;
endpackage : pflb_pkg

//--- include/pflb_sense_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pflb_sense_if;
    logic fault_raw;
    logic limit_raw;
    logic fault_blanked;
    logic limit_blanked;
    logic blanking;
    modport owner (output fault_raw, output limit_raw, input fault_blanked, input limit_blanked, input blanking);
    modport blanker (input fault_raw, input limit_raw, output fault_blanked, output limit_blanked, output blanking);
endinterface : pflb_sense_if
`default_nettype wire

//--- core/pflb_blanker.sv
`timescale 1ns/1ps
`default_nettype none
module pflb_blanker
    import pflb_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_tick,
    input  wire logic [15:0] i_ctrl,
    input  wire logic [15:0] i_time,
    input  wire logic        i_hi,
    input  wire logic        i_lo,
    input  wire logic        i_sel_sig,
    pflb_sense_if.blanker    sense
);
    logic              hi_q;
    logic              lo_q;
    logic [15:0]       cnt;
    logic [15:0]       next_cnt;
    pflb_blank_state_t state;
    pflb_blank_state_t next_state;
    logic              trig;
    logic              level_blank;

    // ==========================================
    // edge trigger and level blanking
    always_comb begin
        trig = (i_ctrl[BIT_HI_RISE] & i_hi & ~hi_q) | (i_ctrl[BIT_HI_FALL] & ~i_hi & hi_q)
             | (i_ctrl[BIT_LO_RISE] & i_lo & ~lo_q) | (i_ctrl[BIT_LO_FALL] & ~i_lo & lo_q);
        level_blank = (i_ctrl[BIT_SEL_HIGH] & i_sel_sig) | (i_ctrl[BIT_SEL_LOW] & ~i_sel_sig)
                    | (i_ctrl[BIT_HI_HIGH] & i_hi) | (i_ctrl[BIT_HI_LOW] & ~i_hi)
                    | (i_ctrl[BIT_LO_HIGH] & i_lo) | (i_ctrl[BIT_LO_LOW] & ~i_lo);
    end

    // ==========================================
    // blanking counter
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            PFLB_IDLE: begin
                if (trig && i_time != 16'h0000) begin
                    next_state = PFLB_BLANK;
                    next_cnt   = i_time;
                end
            end
            PFLB_BLANK: begin
                if (trig) begin
                    next_cnt = i_time;
                end else if (i_tick) begin
                    next_cnt = cnt - 16'h0001;
                    if (cnt == 16'h0001) begin
                        next_state = PFLB_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= PFLB_IDLE;
            cnt   <= 16'h0000;
            hi_q  <= 1'b0;
            lo_q  <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            hi_q  <= i_hi;
            lo_q  <= i_lo;
        end
    end

    // ==========================================
    // gating of sensed inputs
    always_comb begin
        sense.blanking      = (state == PFLB_BLANK) | level_blank;
        sense.fault_blanked = sense.fault_raw & ~(i_ctrl[BIT_FLT_BLANK] & sense.blanking);
        sense.limit_blanked = sense.limit_raw & ~(i_ctrl[BIT_LIM_BLANK] & sense.blanking);
    end
endmodule : pflb_blanker
`default_nettype wire

//--- core/pflb_fault_leb.sv
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pflb_fault_leb
    import pflb_pkg::*;
#(
    parameter int PRESCALE = 1
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst,
    input  wire logic [3:0]            i_addr,
    input  wire logic [15:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [15:0]           o_rdata,
    input  wire logic                  i_pwm_enable,
    input  wire logic                  i_pwm_high,
    input  wire logic                  i_pwm_low,
    input  wire logic [N_FAULTS-1:0]   i_fault_in,
    input  wire logic                  i_limit_in,
    input  wire logic [(1<<AUX_SEL_W)-1:0] i_blank_sources,
    output logic                       o_pwm_high_out,
    output logic                       o_pwm_low_out,
    output logic                       o_safety_pin_owned,
    output logic                       o_fault_active,
    output logic                       o_limit_active
);
    logic [15:0]          blank_ctrl;
    logic [15:0]          next_blank_ctrl;
    logic [6:0]           fault_ctrl;
    logic [6:0]           next_fault_ctrl;
    logic [15:0]          blank_time;
    logic [15:0]          next_blank_time;
    logic [AUX_SEL_W-1:0] aux_sel;
    logic [AUX_SEL_W-1:0] next_aux_sel;
    logic                 latched;
    logic                 next_latched;
    logic [15:0]          rdata;
    logic [15:0]          next_rdata;
    logic [15:0]          pre_cnt;
    logic [15:0]          next_pre_cnt;
    logic                 tick;
    logic                 fault_now;
    logic                 cycle_fault;
    logic                 pwm_h_q;
    logic                 pwm_l_q;
    logic                 next_pwm_h;
    logic                 next_pwm_l;
    logic                 clear_req;

    pflb_sense_if sense ();

    // ==========================================
    // blanking timer clock enable
    always_comb begin
        tick         = (pre_cnt == 16'(PRESCALE - 1));
        next_pre_cnt = tick ? 16'h0000 : pre_cnt + 16'h0001;
    end

    // ==========================================
    // fault sensing
    always_comb begin
        sense.fault_raw = |(i_fault_in & fault_ctrl[FAULT_EN_LSB +: N_FAULTS]);
        sense.limit_raw = i_limit_in;
    end

    pflb_blanker u_blanker (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_tick    (tick),
        .i_ctrl    (blank_ctrl),
        .i_time    (blank_time),
        .i_hi      (pwm_h_q),
        .i_lo      (pwm_l_q),
        .i_sel_sig (i_blank_sources[aux_sel]),
        .sense     (sense)
    );

    // ==========================================
    // registers and fault latch
    always_comb begin
        next_blank_ctrl = blank_ctrl;
        next_fault_ctrl = fault_ctrl;
        next_blank_time = blank_time;
        next_aux_sel    = aux_sel;
        next_rdata      = 16'h0000;
        clear_req       = 1'b0;
        fault_now       = sense.fault_blanked & (fault_ctrl[1:0] != MODE_OFF);
        cycle_fault     = fault_now & (fault_ctrl[1:0] == MODE_CYCLE);
        if (i_wr) begin
            unique case (i_addr)
                ADDR_BLANK_CTRL:  next_blank_ctrl = i_wdata & BLANK_CTRL_MASK;
                ADDR_FAULT_CTRL:  next_fault_ctrl = i_wdata[6:0];
                ADDR_BLANK_TIME:  next_blank_time = i_wdata;
                ADDR_AUX_CTRL:    next_aux_sel    = i_wdata[AUX_SEL_W-1:0];
                ADDR_FAULT_CLEAR: clear_req       = i_wdata[0];
                default:          ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                ADDR_BLANK_CTRL:  next_rdata = blank_ctrl;
                ADDR_FAULT_CTRL:  next_rdata = {9'h000, fault_ctrl};
                ADDR_BLANK_TIME:  next_rdata = blank_time;
                ADDR_AUX_CTRL:    next_rdata = {12'h000, aux_sel};
                ADDR_STATUS:      next_rdata = {12'h000, sense.blanking, sense.limit_blanked, fault_now, latched};
                default:          next_rdata = 16'h0000;
            endcase
        end
        next_latched = latched;
        if (clear_req && !i_fault_in[SAFETY_IDX]) begin
            next_latched = 1'b0;
        end
        if (fault_now && fault_ctrl[1:0] == MODE_LATCHED) begin
            next_latched = 1'b1;
        end
        if (latched || cycle_fault || !i_pwm_enable) begin
            next_pwm_h = 1'b0;
            next_pwm_l = 1'b0;
        end else begin
            next_pwm_h = i_pwm_high;
            next_pwm_l = i_pwm_low;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            blank_ctrl <= BLANK_CTRL_RESET;
            fault_ctrl <= FAULT_CTRL_RESET;
            latched    <= 1'b1;
            blank_time <= BLANK_TIME_RESET;
            aux_sel    <= '0;
            rdata      <= 16'h0000;
            pre_cnt    <= 16'h0000;
            pwm_h_q    <= 1'b0;
            pwm_l_q    <= 1'b0;
        end else begin
            blank_ctrl <= next_blank_ctrl;
            fault_ctrl <= next_fault_ctrl;
            latched    <= next_latched;
            blank_time <= next_blank_time;
            aux_sel    <= next_aux_sel;
            rdata      <= next_rdata;
            pre_cnt    <= next_pre_cnt;
            pwm_h_q    <= next_pwm_h;
            pwm_l_q    <= next_pwm_l;
        end
    end

    // ==========================================
    // outputs
    always_comb begin
        o_rdata            = rdata;
        o_pwm_high_out     = pwm_h_q;
        o_pwm_low_out      = pwm_l_q;
        o_safety_pin_owned = i_rst | fault_ctrl[FAULT_EN_LSB + SAFETY_IDX];
        o_fault_active     = latched | cycle_fault;
        o_limit_active     = sense.limit_blanked;
    end
endmodule : pflb_fault_leb
`default_nettype wire

//--- testbench/pflb_fault_src.sv
`timescale 1ns/1ps
`default_nettype none
module pflb_fault_src (
    input  wire logic       i_mclk,
    input  wire logic [4:0] i_req,
    input  wire logic       i_lim_req,
    output logic      [4:0] o_fault_in,
    output logic            o_limit_in
);
    // ==========================================
    // external fault and limit sources
    always_ff @(posedge i_mclk) begin
        o_fault_in <= i_req;
        o_limit_in <= i_lim_req;
    end
endmodule : pflb_fault_src
`default_nettype wire

//--- testbench/pflb_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pflb_asserts (
    input wire logic                          i_mclk,
    input wire logic                          i_rst,
    input wire logic                          i_rd,
    input wire logic [15:0]                   o_rdata,
    input wire logic                          i_pwm_enable,
    input wire logic                          i_pwm_high,
    input wire logic                          i_pwm_low,
    input wire logic [pflb_pkg::N_FAULTS-1:0] i_fault_in,
    input wire logic                          i_limit_in,
    input wire logic                          o_pwm_high_out,
    input wire logic                          o_pwm_low_out,
    input wire logic                          o_safety_pin_owned,
    input wire logic                          o_fault_active,
    input wire logic                          o_limit_active
);
    import pflb_pkg::*;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    // ==========================================
    // checks
    chk_fault_holds_safe:
    assert property (o_fault_active && $past(o_fault_active) |-> !o_pwm_high_out && !o_pwm_low_out)
        else $error("outputs not safe under fault");
    chk_fault_has_cause:
    assert property ($rose(o_fault_active) |-> (i_fault_in != 0) || ($past(i_fault_in) != 0))
        else $error("fault without input");
    chk_outputs_follow:
    assert property ($past(i_pwm_enable) && !$past(o_fault_active) && !o_fault_active
        |-> o_pwm_high_out == $past(i_pwm_high) && o_pwm_low_out == $past(i_pwm_low))
        else $error("outputs do not follow generator");
    chk_disabled_low:
    assert property (!i_pwm_enable |=> !o_pwm_high_out && !o_pwm_low_out)
        else $error("outputs driven while disabled");
    chk_owned_release:
    assert property ($fell(i_rst) |-> o_safety_pin_owned)
        else $error("safety pin not owned after reset");
    chk_reset_latched:
    assert property ($fell(i_rst) |-> o_fault_active && !o_pwm_high_out && !o_pwm_low_out)
        else $error("reset state not fail safe");
    chk_limit_cause:
    assert property (o_limit_active |-> i_limit_in)
        else $error("limit without input");
    chk_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read cycle");
    cov_fault_rise: cover property ($rose(o_fault_active));
    cov_fault_fall: cover property ($fell(o_fault_active));
    cov_limit_seen: cover property (o_limit_active);
endmodule : pflb_asserts
bind pflb_fault_leb pflb_asserts u_chk (
    .i_mclk, .i_rst, .i_rd, .o_rdata, .i_pwm_enable, .i_pwm_high, .i_pwm_low, .i_fault_in,
    .i_limit_in, .o_pwm_high_out, .o_pwm_low_out, .o_safety_pin_owned, .o_fault_active, .o_limit_active
);
`default_nettype wire

//--- testbench/test_pflb_fault_leb.sv
`timescale 1ns/1ps
`default_nettype none
module test_pflb_fault_leb;
    import pflb_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] i_blank_sources = 16'h0000;
    logic        i_pwm_enable = 1'b0;
    logic        i_pwm_high = 1'b0;
    logic        i_pwm_low = 1'b0;
    logic [4:0]  flt_req = 5'h00;
    logic        lim_req = 1'b0;
    logic [4:0]  i_fault_in;
    logic        i_limit_in;
    logic [15:0] o_rdata;
    logic        o_pwm_high_out, o_pwm_low_out, o_safety_pin_owned, o_fault_active, o_limit_active;
    int          num_errors = 0;
    int          compares = 0;
    int          seed = 55;
    logic [15:0] rnd;
    logic [15:0] ctl [3] = '{16'h8c00, 16'h4c00, 16'h8800};
    always #20 i_mclk = ~i_mclk;
    pflb_fault_src u_src (.i_mclk, .i_req(flt_req), .i_lim_req(lim_req), .o_fault_in(i_fault_in),
        .o_limit_in(i_limit_in));
    pflb_fault_leb #(.PRESCALE(1)) u_dut (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_pwm_enable, .i_pwm_high, .i_pwm_low, .i_fault_in, .i_limit_in, .i_blank_sources,
        .o_pwm_high_out, .o_pwm_low_out, .o_safety_pin_owned, .o_fault_active, .o_limit_active);
    // ==========================================
    // helpers
    function automatic logic blank_exp(input int k);
        return !(k == 0 || k == 2 || k == 5);
    endfunction : blank_exp
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk("rdata", e, o_rdata & m);
    endtask : rd
    function automatic logic [15:0] outs();
        return {13'h0, o_fault_active, o_pwm_high_out, o_pwm_low_out};
    endfunction : outs
    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge i_mclk);
        num_errors++;
        conclude();
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        tick(0);
        chk("owned", 16'h0001, {15'h0, o_safety_pin_owned});
        chk("reset_outs", 16'h0004, outs());
        rd(ADDR_FAULT_CTRL, 16'h007f, {9'h0, FAULT_CTRL_RESET});
        rd(ADDR_BLANK_CTRL, 16'hffff, BLANK_CTRL_RESET);
        rd(4'hf, 16'hffff, 16'h0000);
        @(posedge i_mclk);
        i_pwm_enable <= 1'b1;
        i_pwm_high <= 1'b1;
        i_pwm_low <= 1'b1;
        flt_req <= 5'h10;
        tick(3);
        for (int m = 0; m < 4; m++) begin
            if (m != 2) begin
                wr(ADDR_FAULT_CTRL, 16'h0040 | 16'(m));
                rd(ADDR_FAULT_CTRL, 16'h007f, 16'h0040 | 16'(m));
            end
        end
        // mode off, pin still high: clear must be refused
        wr(ADDR_FAULT_CLEAR, 16'h0001);
        rd(ADDR_STATUS, 16'h0001, 16'h0001);
        wr(ADDR_FAULT_CTRL, 16'h0040);
        @(posedge i_mclk);
        flt_req <= 5'h00;
        tick(3);
        chk("latched", 16'h0004, outs());
        wr(ADDR_FAULT_CLEAR, 16'h0001);
        tick(2);
        chk("cleared", 16'h0003, outs());
        repeat (6) begin
            rnd = 16'($random(seed));
            wr(ADDR_BLANK_CTRL, rnd);
            rd(ADDR_BLANK_CTRL, 16'hffff, rnd & BLANK_CTRL_MASK);
        end
        wr(ADDR_BLANK_CTRL, 16'h0000);
        for (int j = 0; j < 2; j++) begin
            rnd = (j == 0) ? 16'h007d : 16'h0041;
            wr(ADDR_FAULT_CTRL, rnd);
            for (int i = 0; i < 4; i++) begin
                @(posedge i_mclk);
                flt_req <= 5'(1 << i);
                tick(3);
                chk("fault", rnd[2+i] ? 16'h0004 : 16'h0003, outs());
                @(posedge i_mclk);
                flt_req <= 5'h00;
                tick(3);
            end
        end
        wr(ADDR_AUX_CTRL, 16'h0002);
        @(posedge i_mclk);
        i_pwm_high <= 1'b0;
        i_pwm_low <= 1'b0;
        i_blank_sources <= 16'h0004;
        lim_req <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            wr(ADDR_BLANK_CTRL, 16'h0c00 | 16'(1 << k));
            tick(1);
            chk("state_blank", {15'h0, blank_exp(k)}, {15'h0, o_limit_active});
        end
        wr(ADDR_BLANK_TIME, 16'h0005);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_BLANK_CTRL, ctl[k]);
            tick(2);
            @(posedge i_mclk);
            i_pwm_high <= 1'b1;
            tick(3);
            chk("edge_blank", {15'h0, k != 0}, {15'h0, o_limit_active});
            tick(12);
            chk("blank_end", 16'h0001, {15'h0, o_limit_active});
            @(posedge i_mclk);
            i_pwm_high <= 1'b0;
        end
        @(posedge i_mclk);
        i_rst <= 1'b1;
        tick(1);
        chk("rst_owned", 16'h0001, {15'h0, o_safety_pin_owned});
        chk("rst_outs", 16'h0004, outs());
        @(posedge i_mclk);
        i_rst <= 1'b0;
        tick(2);
        rd(ADDR_FAULT_CTRL, 16'h007f, {9'h0, FAULT_CTRL_RESET});
        conclude();
    end
endmodule : test_pflb_fault_leb
`default_nettype wire
